// ===== flash_host_ctrl.sv
// Purpose : Host controller that drives a byte-wide sector flash over its pins
// Assumes : Flash data pins come from outside the clock domain; user port is synchronous
// Notes   : One request at a time; loads of a sector form a batch closed by OP_FINISH
module flash_host_ctrl
  import flash_host_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC,
  parameter int WC_CYCLES  = WC_CYC
)(
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_op,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_data,
  input  wire logic              req_full_sector,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_data,
  output logic [ERR_W-1:0]       rsp_err,
  output logic                   load_window_open,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic [DATA_W-1:0]      flash_data_out,
  output logic                   flash_data_oe,
  input  wire logic [DATA_W-1:0] flash_data_in
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (BLC_CYCLES < 1 || BLC_CYCLES >= (1 << WIN_W))
  begin : g_blc_chk
    $error("BLC_CYCLES out of range for the window counter");
  end
  if (WC_CYCLES < 1 || WC_CYCLES + 4 * RD_CYC >= (1 << TMO_W))
  begin : g_wc_chk
    $error("WC_CYCLES out of range for the timeout counter");
  end

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_WR_LOW    = 3'b001,
    ST_WR_HIGH   = 3'b010,
    ST_RD_LOW    = 3'b011,
    ST_RD_HIGH   = 3'b100,
    ST_WAIT_WIN  = 3'b101,
    ST_POLL_LOW  = 3'b110,
    ST_POLL_HIGH = 3'b111
  } state_t;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  state_t              state_r, state_nxt;
  logic [ADDR_W-1:0]   addr_r, addr_nxt;
  logic [DATA_W-1:0]   wdata_r, wdata_nxt;
  logic                ce_n_r, ce_n_nxt;
  logic                oe_n_r, oe_n_nxt;
  logic                we_n_r, we_n_nxt;
  logic                data_oe_r, data_oe_nxt;
  logic                rsp_valid_r, rsp_valid_nxt;
  logic [DATA_W-1:0]   rsp_data_r, rsp_data_nxt;
  logic [ERR_W-1:0]    rsp_err_r, rsp_err_nxt;
  logic                batch_r, batch_nxt;
  logic [SECTOR_W-1:0] sector_r, sector_nxt;
  logic [COUNT_W-1:0]  count_r, count_nxt;
  logic                need_full_r, need_full_nxt;
  logic                is_load_r, is_load_nxt;
  logic                first_r, first_nxt;
  logic                prev_tog_r, prev_tog_nxt;
  logic [ADDR_W-1:0]   poll_addr_r, poll_addr_nxt;
  logic [DATA_W-1:0]   din_s1_r, din_s2_r;
  logic                ph_load, win_load, tmo_load;
  logic [PHASE_W-1:0]  ph_val;
  logic                ph_last, win_busy, win_last, tmo_busy;
  logic                cur_tog;

  // ****************************************************************
  // Timers
  // ****************************************************************
  phase_timer #(.W(PHASE_W)) u_phase (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (ph_load),
    .load_val (ph_val),
    .busy     (),
    .last     (ph_last)
  );

  // Byte-load window restarts on every completed load
  phase_timer #(.W(WIN_W)) u_window (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (win_load),
    .load_val (WIN_W'(BLC_CYCLES)),
    .busy     (win_busy),
    .last     (win_last)
  );

  // Longest program plus two polls, so the reads that confirm completion still fit
  phase_timer #(.W(TMO_W)) u_timeout (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (tmo_load),
    .load_val (TMO_W'(WC_CYCLES + 4 * RD_CYC)),
    .busy     (tmo_busy),
    .last     ()
  );

  // Flash data pins are asynchronous to core_clk
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      din_s1_r <= '0;
      din_s2_r <= '0;
    end
    else
    begin
      din_s1_r <= flash_data_in;
      din_s2_r <= din_s1_r;
    end
  end

  assign cur_tog = din_s2_r[TOGGLE_BIT];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Next-state logic for the pin sequencer and batch bookkeeping
  always_comb
  begin
    state_nxt     = state_r;
    addr_nxt      = addr_r;
    wdata_nxt     = wdata_r;
    ce_n_nxt      = ce_n_r;
    oe_n_nxt      = oe_n_r;
    we_n_nxt      = we_n_r;
    data_oe_nxt   = data_oe_r;
    rsp_valid_nxt = 1'b0;
    rsp_data_nxt  = rsp_data_r;
    rsp_err_nxt   = rsp_err_r;
    batch_nxt     = batch_r;
    sector_nxt    = sector_r;
    count_nxt     = count_r;
    need_full_nxt = need_full_r;
    is_load_nxt   = is_load_r;
    first_nxt     = first_r;
    prev_tog_nxt  = prev_tog_r;
    poll_addr_nxt = poll_addr_r;
    ph_load       = 1'b0;
    ph_val        = '0;
    win_load      = 1'b0;
    tmo_load      = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          rsp_err_nxt = '0;
          case (op_t'(req_op))
            OP_READ:
            begin
              addr_nxt  = req_addr;
              ce_n_nxt  = 1'b0;
              oe_n_nxt  = 1'b0;
              ph_load   = 1'b1;
              ph_val    = PHASE_W'(RD_CYC);
              state_nxt = ST_RD_LOW;
            end
            OP_LOAD:
            begin
              // A lapsed window means the flash is already programming and would drop the byte
              if (batch_r && !win_busy)
              begin
                rsp_err_nxt[ERR_LATE] = 1'b1;
                rsp_valid_nxt         = 1'b1;
              end
              else if (batch_r && req_addr[ADDR_W-1:SECTOR_LSB] != sector_r)
              begin
                rsp_err_nxt[ERR_SECTOR] = 1'b1;
                rsp_valid_nxt           = 1'b1;
              end
              else
              begin
                addr_nxt    = req_addr;
                wdata_nxt   = req_data;
                is_load_nxt = 1'b1;
                ce_n_nxt    = 1'b0;
                we_n_nxt    = 1'b0;
                oe_n_nxt    = 1'b1;
                data_oe_nxt = 1'b1;
                ph_load     = 1'b1;
                ph_val      = PHASE_W'(WP_CYC);
                state_nxt   = ST_WR_LOW;
              end
            end
            OP_CMD:
            begin
              // Upper lines driven low; only the low fifteen take part in matching
              addr_nxt      = {{(ADDR_W - CMD_ADDR_W){1'b0}}, req_addr[CMD_ADDR_W-1:0]};
              wdata_nxt     = req_data;
              is_load_nxt   = 1'b0;
              need_full_nxt = need_full_r | req_full_sector;
              ce_n_nxt      = 1'b0;
              we_n_nxt      = 1'b0;
              oe_n_nxt      = 1'b1;
              data_oe_nxt   = 1'b1;
              ph_load       = 1'b1;
              ph_val        = PHASE_W'(WP_CYC);
              state_nxt     = ST_WR_LOW;
            end
            default:
            begin
              // Finish: wait out the load window so programming has started
              poll_addr_nxt = addr_r;
              first_nxt     = 1'b1;
              state_nxt     = ST_WAIT_WIN;
            end
          endcase
        end
      end
      ST_WR_LOW:
      begin
        if (ph_last)
        begin
          we_n_nxt  = 1'b1;
          ce_n_nxt  = 1'b1;
          ph_load   = 1'b1;
          ph_val    = PHASE_W'(WPH_CYC);
          state_nxt = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH:
      begin
        if (ph_last)
        begin
          data_oe_nxt   = 1'b0;
          rsp_valid_nxt = 1'b1;
          state_nxt     = ST_IDLE;
          if (is_load_r)
          begin
            win_load  = 1'b1;
            batch_nxt = 1'b1;
            if (!batch_r)
              sector_nxt = addr_r[ADDR_W-1:SECTOR_LSB];
            count_nxt = batch_r ? count_r + COUNT_W'(1) : COUNT_W'(1);
          end
        end
      end
      ST_RD_LOW:
      begin
        if (ph_last)
        begin
          rsp_data_nxt = din_s2_r;
          oe_n_nxt     = 1'b1;
          ce_n_nxt     = 1'b1;
          ph_load      = 1'b1;
          ph_val       = PHASE_W'(RD_CYC);
          state_nxt    = ST_RD_HIGH;
        end
      end
      ST_RD_HIGH:
      begin
        if (ph_last)
        begin
          rsp_valid_nxt = 1'b1;
          state_nxt     = ST_IDLE;
        end
      end
      ST_WAIT_WIN:
      begin
        if (!win_busy || win_last)
        begin
          // A protection batch must have filled the whole sector
          if (need_full_r && count_r != COUNT_W'(SECTOR_BYTES))
            rsp_err_nxt[ERR_SHORT] = 1'b1;
          batch_nxt     = 1'b0;
          need_full_nxt = 1'b0;
          addr_nxt      = poll_addr_r;
          ce_n_nxt      = 1'b0;
          oe_n_nxt      = 1'b0;
          tmo_load      = 1'b1;
          ph_load       = 1'b1;
          ph_val        = PHASE_W'(RD_CYC);
          state_nxt     = ST_POLL_LOW;
        end
      end
      ST_POLL_LOW:
      begin
        if (ph_last)
        begin
          rsp_data_nxt = din_s2_r;
          prev_tog_nxt = cur_tog;
          first_nxt    = 1'b0;
          oe_n_nxt     = 1'b1;
          ce_n_nxt     = 1'b1;
          // Only the change between reads counts, never the level itself
          if (!first_r && cur_tog == prev_tog_r)
          begin
            rsp_valid_nxt = 1'b1;
            state_nxt     = ST_IDLE;
          end
          else if (!tmo_busy)
          begin
            rsp_err_nxt[ERR_TIMEOUT] = 1'b1;
            rsp_valid_nxt            = 1'b1;
            state_nxt                = ST_IDLE;
          end
          else
          begin
            ph_load   = 1'b1;
            ph_val    = PHASE_W'(RD_CYC);
            state_nxt = ST_POLL_HIGH;
          end
        end
      end
      ST_POLL_HIGH:
      begin
        // Gate-high gap between polls is what makes the toggle bit move
        if (ph_last)
        begin
          ce_n_nxt  = 1'b0;
          oe_n_nxt  = 1'b0;
          ph_load   = 1'b1;
          ph_val    = PHASE_W'(RD_CYC);
          state_nxt = ST_POLL_LOW;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Registers of the sequencer
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r     <= ST_IDLE;
      addr_r      <= '0;
      wdata_r     <= '0;
      ce_n_r      <= 1'b1;
      oe_n_r      <= 1'b1;
      we_n_r      <= 1'b1;
      data_oe_r   <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= '0;
      rsp_err_r   <= '0;
      batch_r     <= 1'b0;
      sector_r    <= '0;
      count_r     <= '0;
      need_full_r <= 1'b0;
      is_load_r   <= 1'b0;
      first_r     <= 1'b1;
      prev_tog_r  <= 1'b0;
      poll_addr_r <= '0;
    end
    else
    begin
      state_r     <= state_nxt;
      addr_r      <= addr_nxt;
      wdata_r     <= wdata_nxt;
      ce_n_r      <= ce_n_nxt;
      oe_n_r      <= oe_n_nxt;
      we_n_r      <= we_n_nxt;
      data_oe_r   <= data_oe_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r  <= rsp_data_nxt;
      rsp_err_r   <= rsp_err_nxt;
      batch_r     <= batch_nxt;
      sector_r    <= sector_nxt;
      count_r     <= count_nxt;
      need_full_r <= need_full_nxt;
      is_load_r   <= is_load_nxt;
      first_r     <= first_nxt;
      prev_tog_r  <= prev_tog_nxt;
      poll_addr_r <= poll_addr_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign req_ready        = (state_r == ST_IDLE);
  assign rsp_valid        = rsp_valid_r;
  assign rsp_data         = rsp_data_r;
  assign rsp_err          = rsp_err_r;
  assign load_window_open = batch_r & win_busy;
  assign flash_addr       = addr_r;
  assign flash_ce_n       = ce_n_r;
  assign flash_oe_n       = oe_n_r;
  assign flash_we_n       = we_n_r;
  assign flash_data_out   = wdata_r;
  assign flash_data_oe    = data_oe_r;

endmodule

// ===== flash_host_pkg.sv
// Purpose : Shared constants for the parallel sector flash host controller
// Assumes : core_clk at 250 MHz; the flash is byte wide with 18 address lines
// Notes   : Times are kept in their printed units; cycle counts derive from them
package flash_host_pkg;

  // ****************************************************************
  // Pin geometry
  // ****************************************************************
  localparam int ADDR_W       = 18;
  localparam int DATA_W       = 8;
  localparam int CMD_ADDR_W   = 15;
  localparam int SECTOR_LSB   = 8;
  localparam int SECTOR_W     = ADDR_W - SECTOR_LSB;
  localparam int SECTOR_BYTES = 256;
  localparam int COUNT_W      = 9;
  localparam int TOGGLE_BIT   = 6;

  // ****************************************************************
  // Timing, printed units then cycles
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_WP_NS       = 90;   // Write pulse low, least
  localparam int T_WPH_NS      = 100;  // Write pulse high, least
  localparam int T_AH_NS       = 50;   // Address hold after strobe rise, least
  localparam int T_RD_NS       = 200;  // Read strobe low and high, covers access and gate high pulse
  localparam int T_BLC_US      = 150;  // Byte-load window, longest
  localparam int T_WC_MS       = 10;   // Program cycle, longest
  localparam int WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC_RAW   = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AH_CYC        = (T_AH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC       = (WPH_CYC_RAW > AH_CYC) ? WPH_CYC_RAW : AH_CYC;
  localparam int RD_CYC        = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLC_CYC       = (T_BLC_US * 1000) / CLK_PERIOD_NS;
  localparam int WC_CYC        = (T_WC_MS * 1000000) / CLK_PERIOD_NS;
  localparam int PHASE_W       = 8;
  localparam int WIN_W         = 16;
  localparam int TMO_W         = 22;

  // ****************************************************************
  // Request codes and error flags
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_READ   = 2'b00,
    OP_LOAD   = 2'b01,
    OP_CMD    = 2'b10,
    OP_FINISH = 2'b11
  } op_t;

  localparam int ERR_W        = 4;
  localparam int ERR_LATE     = 0;
  localparam int ERR_SECTOR   = 1;
  localparam int ERR_SHORT    = 2;
  localparam int ERR_TIMEOUT  = 3;

endpackage

// ===== phase_timer.sv
// Purpose : Down counter that times one phase and pulses on its last cycle
// Assumes : load and count share core_clk
// Notes   : A phase of N cycles is loaded with N; busy holds for those N cycles
module phase_timer
  import flash_host_pkg::*;
#(
  parameter int W = 8
)(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              busy,
  output logic              last
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Load wins over the running count so back to back phases chain cleanly
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (load)
      cnt_nxt = load_val;
    else if (cnt_r != '0)
      cnt_nxt = cnt_r - W'(1);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign busy = (cnt_r != '0);
  assign last = (cnt_r == W'(1));

endmodule

// ===== flash_host_ctrl_asserts.sv
// Purpose : Pin and handshake checks for the flash host controller
// Assumes : One clock domain; rstn low active
// Notes   : Bound to every controller instance at the foot of this file
module flash_host_ctrl_asserts
  import flash_host_pkg::*;
#(
  parameter int BLC_CYCLES = BLC_CYC
)(
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic [1:0]        req_op,
  input wire logic              rsp_valid,
  input wire logic              load_window_open,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_ce_n,
  input wire logic              flash_oe_n,
  input wire logic              flash_we_n,
  input wire logic [DATA_W-1:0] flash_data_out,
  input wire logic              flash_data_oe
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic              oe_r, we_r;
  logic [9:0]        gap_r, gap_nxt, sec_r, sec_nxt;
  logic [ADDR_W-1:0] radr_r, radr_nxt;
  logic [7:0]        wel_r, wel_nxt;
  logic [31:0]       win_r, win_nxt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Gap since last read strobe, batch sector, strobe and window run lengths
  always_comb
  begin
    gap_nxt  = (oe_r && !flash_oe_n) ? 10'h000 : gap_r + {9'h000, gap_r != 10'h3FF};
    radr_nxt = (oe_r && !flash_oe_n) ? flash_addr : radr_r;
    sec_nxt  = (we_r && !flash_we_n && !load_window_open) ? flash_addr[17:8] : sec_r;
    wel_nxt  = flash_we_n ? 8'h00 : wel_r + 8'h01;
    win_nxt  = load_window_open ? win_r + 32'h1 : 32'h0;
  end

  // Registers only; saturating gap keeps idle periods from wrapping
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {oe_r, we_r} <= 2'h3;
      {gap_r, sec_r, radr_r, wel_r, win_r} <= '0;
    end
    else
    begin
      {oe_r, we_r} <= {flash_oe_n, flash_we_n};
      {gap_r, sec_r, radr_r, wel_r, win_r} <= {gap_nxt, sec_nxt, radr_nxt, wel_nxt, win_nxt};
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  oe_gate_a: assert property (!flash_we_n && !flash_ce_n |-> flash_oe_n)
    else $error("gate low during a write");
  we_select_a: assert property (!flash_we_n |-> !flash_ce_n && flash_data_oe)
    else $error("write strobe without select or data drive");
  sector_same_a: assert property ($fell(flash_we_n) && load_window_open |-> flash_addr[17:8] == sec_r)
    else $error("sector changed within a batch");
  load_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_data_out))
    else $error("address or data moved during write strobe");
  pulse_width_a: assert property ($rose(flash_we_n) |-> wel_r == WP_CYC[7:0])
    else $error("write strobe width wrong");
  addr_hold_a: assert property ($rose(flash_we_n) |-> ##5 ($stable(flash_addr) && flash_we_n)[*8])
    else $error("address not held after strobe");
  poll_addr_a: assert property ($fell(flash_oe_n) && gap_r == 10'd99 |-> flash_addr == radr_r)
    else $error("poll address moved");
  window_max_a: assert property (win_r <= BLC_CYCLES)
    else $error("load window outlived its limit");
  read_answer_a: assert property (req_valid && req_ready && req_op == 2'b00 |-> ##101 rsp_valid)
    else $error("read answer late or missing");

  load_c: cover property ($rose(load_window_open));
  poll_c: cover property ($fell(flash_oe_n) && gap_r < 10'd100);
  write_c: cover property ($rose(flash_we_n));
endmodule

bind flash_host_ctrl flash_host_ctrl_asserts #(.BLC_CYCLES(BLC_CYCLES)) chk_u (
  .core_clk(core_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
  .rsp_valid(rsp_valid), .load_window_open(load_window_open), .flash_addr(flash_addr),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_data_out(flash_data_out), .flash_data_oe(flash_data_oe));

// ===== flash_model.sv
// Purpose : Behavioural byte-wide sector flash for the host bench
// Assumes : Pins sampled on core_clk; command codes are plain stand-ins
// Notes   : Released data lines show the inverse of the last driven value
module flash_model
  import flash_host_pkg::*;
#(
  parameter int          BLC      = 40,
  parameter int          WC       = 2000,
  parameter logic [14:0] CMD_ADR  = 15'h1234,
  parameter logic [7:0]  ID_ON    = 8'h11,
  parameter logic [7:0]  ID_OFF   = 8'h22,
  parameter logic [7:0]  PROT_ON  = 8'h33,
  parameter logic [7:0]  PROT_OFF = 8'h44,
  parameter logic [7:0]  MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0]  PART_ID  = 8'hC3  // Arbitrary value
)(
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic              core_clk,
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0]      rdata
);
  // ****************************************************************
  // Array, page latch and program timer
  // ****************************************************************
  logic [7:0]   mem [0:2**ADDR_W-1];
  logic [7:0]   page [0:255];
  logic [255:0] got;
  logic [9:0]   sec;
  logic [7:0]   last_b, last_drv, rd_val;
  logic [1:0]   pend;
  logic         loading, busy, tog, id_mode, prot, pwe, pce, poe;
  int           gap, wc;

  // Power-up in array read with no mode pending
  initial
  begin
    foreach (mem[i]) mem[i] = 8'hFF;
    {loading, busy, tog, id_mode, prot, pend, got, last_b, last_drv} = '0;
    {pwe, pce, poe} = 3'h7;
  end

  // Strobe end latches a byte or a command; the timer ignores writes
  always @(posedge core_clk)
  begin
    if (!pwe && we_n && !pce && !busy)
    begin
      if (addr[14:0] == CMD_ADR && wdata inside {ID_ON, ID_OFF, PROT_ON, PROT_OFF})
      begin
        if (wdata == ID_ON) id_mode = 1'b1;
        if (wdata == ID_OFF) id_mode = 1'b0;
        if (wdata == PROT_ON) pend = 2'h1;
        if (wdata == PROT_OFF) pend = 2'h2;
      end
      else
      begin
        {page[addr[7:0]], got[addr[7:0]], sec, last_b} = {wdata, 1'b1, addr[17:8], wdata};
        {loading, gap} = {1'b1, 32'h0};
      end
    end
    else if (loading && gap + 1 >= BLC)
    begin
      {loading, busy, wc} = {2'b01, 32'h0};
      for (int i = 0; i < 256; i++) mem[{sec, i[7:0]}] = got[i] ? page[i] : 8'hXX;
      got = '0;
    end
    else if (loading) gap = gap + 1;
    else if (busy && wc + 1 >= WC)
    begin
      busy = 1'b0;
      if (pend == 2'h1) prot = 1'b1;
      if (pend == 2'h2) prot = 1'b0;
      pend = 2'h0;
    end
    else if (busy) wc = wc + 1;
    if ((poe || pce) && !oe_n && !ce_n && busy) tog = ~tog;
    if (!oe_n && !ce_n) last_drv = rd_val;
    {pwe, pce, poe} = {we_n, ce_n, oe_n};
  end

  // Status while programming, codes in identification mode, else array
  assign rd_val = busy ? {~last_b[7], tog, last_b[5:0]}
                : id_mode ? (addr[0] ? PART_ID : MAKER_ID) : mem[addr];
  assign rdata = (!oe_n && !ce_n) ? rd_val : ~last_drv;
endmodule

// ===== tb_flash_host_ctrl.sv
// Purpose : Self-checking bench for the flash host controller
// Assumes : Short load window and program time via parameters
// Notes   : Each scenario task drives requests and judges the answers
module tb_flash_host_ctrl
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int          BLC = 40;
  localparam int          WC  = 2000;
  localparam logic [17:0] CMD = 18'h01234;
  logic              core_clk = 0, rstn = 0, req_valid = 0, req_full_sector = 0;
  logic [1:0]        req_op = 0;
  logic [ADDR_W-1:0] req_addr = 0, flash_addr;
  logic [DATA_W-1:0] req_data = 0, rsp_data, flash_data_out, flash_data_in, got_d;
  logic [ERR_W-1:0]  rsp_err, got_e;
  logic              req_ready, rsp_valid, load_window_open, flash_ce_n, flash_oe_n, flash_we_n, flash_data_oe;
  int                miscompares = 0, comparisons = 0;

  always #2 core_clk = ~core_clk;

  flash_host_ctrl #(.BLC_CYCLES(BLC), .WC_CYCLES(WC)) dut_u (.core_clk(core_clk), .rstn(rstn),
    .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .req_full_sector(req_full_sector), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
    .load_window_open(load_window_open), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_data_out(flash_data_out),
    .flash_data_oe(flash_data_oe), .flash_data_in(flash_data_in));

  // Flash times its window from strobe rise, well before the host's window starts
  flash_model #(.BLC(BLC + 20), .WC(WC)) mdl_u (.core_clk(core_clk), .addr(flash_addr), .ce_n(flash_ce_n),
    .oe_n(flash_oe_n), .we_n(flash_we_n), .wdata(flash_data_out), .rdata(flash_data_in));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One request, held for one cycle, then a bounded wait for its answer
  task automatic req(input logic [1:0] op, input logic [17:0] a, input logic [7:0] d, input logic f = 0);
    int n;
    n = 0;
    @(posedge core_clk);
    {req_valid, req_op, req_addr, req_data, req_full_sector} <= {1'b1, op, a, d, f};
    @(posedge core_clk);
    req_valid <= 1'b0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (rsp_valid !== 1'b1 && n < 20000);
    if (n >= 20000) check(0, 1);
    {got_d, got_e} = {rsp_data, rsp_err};
  endtask

  task automatic summarize;
    if (miscompares == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Loads, finish, read back loaded and unloaded bytes
  task automatic s_program;
    for (int i = 0; i < 3; i++)
    begin
      req(2'h1, 18'h00510 + i, 8'hA1 + i);
      check(got_e, 4'h0);
    end
    req(2'h3, 18'h0, 8'h0);
    check(got_e, 4'h0);
    check(got_d, 8'hA3);
    for (int i = 0; i < 3; i++)
    begin
      req(2'h0, 18'h00510 + i, 8'h0);
      check(got_d, 8'hA1 + i);
    end
    req(2'h0, 18'h00513, 8'h0);
    check(got_d, 8'hXX);
  endtask

  task automatic s_ident;
    req(2'h2, CMD, mdl_u.ID_ON);
    req(2'h0, 18'h00000, 8'h0);
    check(got_d, mdl_u.MAKER_ID);
    req(2'h0, 18'h00001, 8'h0);
    check(got_d, mdl_u.PART_ID);
    req(2'h2, CMD, mdl_u.ID_OFF);
    req(2'h0, 18'h00510, 8'h0);
    check(got_d, 8'hA1);
  endtask

  // Sector change and a lapsed window are both refused
  task automatic s_refuse;
    req(2'h1, 18'h00600, 8'h01);
    req(2'h1, 18'h00700, 8'h02);
    check(got_e, 4'h2);
    req(2'h3, 18'h0, 8'h0);
    req(2'h1, 18'h00800, 8'h03);
    repeat (BLC + 20) @(posedge core_clk);
    req(2'h1, 18'h00801, 8'h04);
    check(got_e, 4'h1);
    req(2'h3, 18'h0, 8'h0);
  endtask

  // Full sector after protection on; short sector after protection off
  task automatic s_protect;
    req(2'h2, CMD, mdl_u.PROT_ON, 1'b1);
    for (int i = 0; i < 256; i++) req(2'h1, 18'h00900 + i, i[7:0]);
    check(mdl_u.prot, 1'b0);
    req(2'h3, 18'h0, 8'h0);
    check(got_e, 4'h0);
    check(mdl_u.prot, 1'b1);
    req(2'h2, CMD, mdl_u.PROT_OFF, 1'b1);
    for (int i = 0; i < 3; i++) req(2'h1, 18'h00A00 + i, 8'h55);
    req(2'h3, 18'h0, 8'h0);
    check(got_e, 4'h4);
    repeat (BLC + WC) @(posedge core_clk);
    check(mdl_u.prot, 1'b0);
  endtask

  // Reset, then the scenarios in turn
  initial
  begin
    repeat (6) @(posedge core_clk);
    check({flash_ce_n, flash_oe_n, flash_we_n, flash_data_oe, req_ready}, 5'h1D);
    rstn <= 1'b1;
    s_program();
    s_ident();
    s_refuse();
    s_protect();
    summarize();
  end

  // Watchdog well beyond the expected run of about 28000 cycles
  initial
  begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    summarize();
  end
endmodule
